// [hdl/tw_device.sv]
// Device end: command decoder on the link clock, trigger and sleep control on clk.
`timescale 1ns/10ps
`default_nettype none
module tw_device
  import tw_pkg::*;
#(
  parameter int StepCycles = STOP_STEP_CYC,
  parameter int CalCycles = CAL_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  tw_link_if.device lnk,
  input wire logic startEdgeSelect,
  input wire logic [2:0] stopTimeSel,
  output logic txTrigger,
  output logic modData,
  output logic sleeping,
  output logic calibrating,
  output logic coreReset,
  output logic edgeMasked
);
  typedef struct packed {
    logic rstS1;
    logic rstS2;
    logic [47:0] sh;
    logic [3:0] cnt;
    logic act;
    logic tgRst;
    logic tgRel;
    logic tgCore;
  } tw_lnk_t;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_CALIB = 2'h2
  } tw_dev_st_t;

  typedef struct packed {
    tw_dev_st_t st;
    logic prevRst;
    logic prevRel;
    logic prevCore;
    logic dataPrev;
    logic mask;
    logic [23:0] timer;
    logic [3:0] steps;
    logic txTrig;
    logic coreRst;
  } tw_dev_t;

  tw_lnk_t ln_q, ln_d;
  tw_dev_t q, d;
  logic [47:0] shNext;
  logic [3:0] syncV;
  logic dataS, evRst, evRel, evCore, trig;

  // Starting value of the link side: the shifter is filled with ones so no stale prefix matches.
  localparam tw_lnk_t LnRst = '{sh: '1, default: '0};

  // Link side: the line is sampled on the falling clock edge. The link clock stands still
  // during reset, so reset also clears this side directly; the two flops only cover a reset
  // that arrives while the host is clocking.
  always_comb begin
    ln_d = ln_q;
    ln_d.rstS1 = sys_rst;
    ln_d.rstS2 = ln_q.rstS1;
    shNext = {ln_q.sh[46:0], lnk.dataLine};
    ln_d.sh = shNext;
    if (ln_q.rstS2) begin
      ln_d.sh = '1;
      ln_d.cnt = '0;
      ln_d.act = 1'b0;
      ln_d.tgRst = 1'b0;
      ln_d.tgRel = 1'b0;
      ln_d.tgCore = 1'b0;
    end else if (shNext == {PRE_ZEROS, CMD_PORT_RESET}) begin
      ln_d.act = 1'b1;
      ln_d.cnt = '0;
      ln_d.tgRst = ~ln_q.tgRst;
    end else if (ln_q.act) begin
      ln_d.cnt = ln_q.cnt + 4'h1;
      if (ln_q.cnt == 4'hF) begin
        if (shNext[15:0] == CMD_PORT_RELEASE) begin
          ln_d.act = 1'b0;
          ln_d.tgRel = ~ln_q.tgRel;
        end else if (shNext[15:0] == CMD_CORE_RESET) begin
          ln_d.tgCore = ~ln_q.tgCore;
        end
        // Any other word is dropped without effect.
      end
    end
  end

  always_ff @(negedge lnk.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      ln_q <= LnRst;
    end else begin
      ln_q <= ln_d;
    end
  end

  tw_sync #(.W(4)) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({lnk.dataLine, ln_q.tgRst, ln_q.tgRel, ln_q.tgCore}),
    .dout(syncV)
  );

  assign dataS = syncV[3];
  assign evRst = syncV[2] ^ q.prevRst;
  assign evRel = syncV[1] ^ q.prevRel;
  assign evCore = syncV[0] ^ q.prevCore;
  // Selector low starts on a rising edge, high on a falling edge.
  assign trig = !q.mask && !evRst && (startEdgeSelect ? (q.dataPrev && !dataS)
                                                      : (!q.dataPrev && dataS));

  always_comb begin
    d = q;
    d.txTrig = 1'b0;
    d.coreRst = 1'b0;
    d.prevRst = syncV[2];
    d.prevRel = syncV[1];
    d.prevCore = syncV[0];
    d.dataPrev = dataS;
    if (evRst) begin
      d.mask = 1'b1;
    end else if (evRel) begin
      d.mask = 1'b0;
    end
    unique case (q.st)
      ST_SLEEP: begin
        if (trig) begin
          d.st = ST_ACTIVE;
          d.txTrig = 1'b1;
          d.timer = '0;
          d.steps = '0;
        end
      end
      ST_ACTIVE: begin
        if (dataS) begin
          d.timer = '0;
          d.steps = '0;
        end else if (q.timer == 24'(StepCycles - 1)) begin
          d.timer = '0;
          d.steps = q.steps + 4'h1;
          if (q.steps + 4'h1 == tw_stop_steps(stopTimeSel)) begin
            d.st = ST_SLEEP;
          end
        end else begin
          d.timer = q.timer + 24'h1;
        end
      end
      ST_CALIB: begin
        d.timer = q.timer + 24'h1;
        if (q.timer == 24'(CalCycles - 1)) begin
          d.st = ST_SLEEP;
        end
      end
      default: begin
        d.st = ST_SLEEP;
      end
    endcase
    // Core reset clears everything but the port's own mask and starts calibration.
    if (evCore) begin
      d.st = ST_CALIB;
      d.timer = '0;
      d.steps = '0;
      d.txTrig = 1'b0;
      d.coreRst = 1'b1;
    end
    if (sys_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign txTrigger = q.txTrig;
  assign coreReset = q.coreRst;
  assign modData = q.dataPrev && (q.st == ST_ACTIVE);
  assign sleeping = (q.st == ST_SLEEP);
  assign calibrating = (q.st == ST_CALIB);
  assign edgeMasked = q.mask;
endmodule
`default_nettype wire

// [hdl/tw_host.sv]
// Host end: issues command words on a divided link clock.
`timescale 1ns/10ps
`default_nettype none
module tw_host
  import tw_pkg::*;
#(
  parameter int WaitCycles = CAL_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  tw_link_if.host lnk,
  input wire logic cmdValid,
  input wire tw_op_t cmdOp,
  output logic cmdReady,
  input wire logic idleLevel,
  output logic busy
);
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SHIFT = 2'h1,
    H_WAIT = 2'h3
  } tw_host_st_t;

  typedef struct packed {
    tw_host_st_t st;
    logic [47:0] sh;
    logic [5:0] left;
    logic [6:0] div;
    logic sclk;
    logic dataOut;
    logic [15:0] cur;
    logic [15:0] pend;
    logic pendV;
    logic [17:0] waitCnt;
    logic boot;
  } tw_host_t;

  tw_host_t q, d;

  // Loads one word; a port reset carries its zero prefix ahead of the word.
  function automatic tw_host_t load(input tw_host_t s, input logic [15:0] w);
    tw_host_t r;
    logic pre;
    r = s;
    pre = (w == CMD_PORT_RESET);
    r.sh = pre ? {PRE_ZEROS, w} : {w, PRE_ZEROS};
    r.left = pre ? RST_BITS : WORD_BITS;
    r.dataOut = r.sh[47];
    r.cur = w;
    r.div = '0;
    r.sclk = 1'b1;
    r.st = H_SHIFT;
    return r;
  endfunction

  always_comb begin
    d = q;
    unique case (q.st)
      H_IDLE: begin
        d.dataOut = idleLevel;
        if (q.boot) begin
          d = load(q, CMD_PORT_RESET);
          d.pend = CMD_CORE_RESET;
          d.pendV = 1'b1;
          d.boot = 1'b0;
        end else if (cmdValid) begin
          unique case (cmdOp)
            TW_OP_RESET: begin
              d = load(q, CMD_PORT_RESET);
            end
            TW_OP_RELEASE: begin
              d = load(q, CMD_PORT_RELEASE);
            end
            TW_OP_CORE: begin
              d = load(q, CMD_CORE_RESET);
            end
            TW_OP_PREP: begin
              d = load(q, CMD_PORT_RESET);
              d.pend = CMD_PORT_RELEASE;
              d.pendV = 1'b1;
            end
            TW_OP_SLEEP: begin
              d = load(q, CMD_PORT_RESET);
              d.pend = CMD_CORE_RESET;
              d.pendV = 1'b1;
            end
            default: begin
              d.dataOut = idleLevel;
            end
          endcase
        end
      end
      H_SHIFT: begin
        // The first fall comes one half period after the data line drops.
        if (q.div == 7'(HALF_CYC - 1)) begin
          d.div = '0;
          if (q.sclk) begin
            d.sclk = 1'b0;
          end else begin
            d.sclk = 1'b1;
            d.sh = {q.sh[46:0], 1'b0};
            d.left = q.left - 6'h1;
            d.dataOut = q.sh[46];
            if (q.left == 6'h1) begin
              if (q.pendV) begin
                d = load(d, q.pend);
                d.pendV = 1'b0;
              end else if (q.cur == CMD_CORE_RESET) begin
                d.st = H_WAIT;
                d.waitCnt = '0;
                d.dataOut = idleLevel;
              end else begin
                d.st = H_IDLE;
                d.dataOut = idleLevel;
              end
            end
          end
        end else begin
          d.div = q.div + 7'h1;
        end
      end
      H_WAIT: begin
        // No new command may start until calibration has run out.
        d.dataOut = idleLevel;
        d.waitCnt = q.waitCnt + 18'h1;
        if (q.waitCnt == 18'(WaitCycles - 1)) begin
          d.st = H_IDLE;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
    if (sys_rst) begin
      d = '0;
      d.sclk = 1'b1;
      d.boot = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign lnk.sclk = q.sclk;
  assign lnk.dataOut = q.dataOut;
  assign lnk.dataOe = 1'b1;
  assign cmdReady = (q.st == H_IDLE) && !q.boot;
  assign busy = !cmdReady;
endmodule
`default_nettype wire

// [hdl/tw_link_if.sv]
// Link between host and device: clock line and data line.
`timescale 1ns/10ps
`default_nettype none
interface tw_link_if;
  logic sclk;
  logic dataOut;
  logic dataOe;
  logic dataLine;
  // An undriven data line is pulled high.
  assign dataLine = dataOe ? dataOut : 1'b1;
  modport host(output sclk, output dataOut, output dataOe);
  modport device(input sclk, input dataLine);
endinterface
`default_nettype wire

// [hdl/tw_pkg.sv]
// Shared constants and types for the two-wire command port.
package tw_pkg;
  localparam int CLK_MHZ = 250;
  localparam int SCLK_MAX_KHZ = 1000;
  // Half period of the generated link clock, rounded up so the rate never exceeds the limit.
  localparam int HALF_CYC = (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int CAL_TIME_US = 1000;
  localparam int CAL_CYC = CAL_TIME_US * CLK_MHZ;
  localparam int STOP_MIN_MS = 20;
  localparam int STOP_MAX_MS = 90;
  localparam int STOP_STEP_MS = 10;
  localparam int STOP_STEP_CYC = STOP_STEP_MS * 1000 * CLK_MHZ;
  localparam logic [3:0] STOP_MIN_STEPS = 4'(STOP_MIN_MS / STOP_STEP_MS);
  localparam logic [3:0] STOP_MAX_STEPS = 4'(STOP_MAX_MS / STOP_STEP_MS);
  localparam int PRE_ZERO_BITS = 32;
  localparam logic [5:0] WORD_BITS = 6'h10;
  localparam logic [5:0] RST_BITS = 6'h30;
  localparam logic [15:0] CMD_PORT_RESET = 16'h8D00;
  localparam logic [15:0] CMD_PORT_RELEASE = 16'h8D02;
  localparam logic [15:0] CMD_CORE_RESET = 16'hBD01;
  localparam logic [PRE_ZERO_BITS-1:0] PRE_ZEROS = '0;

  typedef enum logic [2:0] {
    TW_OP_RESET = 3'h0,
    TW_OP_RELEASE = 3'h1,
    TW_OP_CORE = 3'h2,
    TW_OP_PREP = 3'h3,
    TW_OP_SLEEP = 3'h4
  } tw_op_t;

  // Stop time in steps of the step time; selector 0 is the shortest.
  function automatic logic [3:0] tw_stop_steps(input logic [2:0] sel);
    logic [3:0] s;
    s = STOP_MIN_STEPS + {1'b0, sel};
    return (s > STOP_MAX_STEPS) ? STOP_MAX_STEPS : s;
  endfunction
endpackage

// [hdl/tw_sync.sv]
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/10ps
`default_nettype none
module tw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tw_sync_t;
  tw_sync_t q, d;

  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    if (sys_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.s2;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench joining host and device ends, plus a device driven directly by the bench.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  import tw_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid = 1'b0;
  tw_op_t cmdOp = TW_OP_RESET;
  logic idleLevel = 1'b0;
  logic startEdgeSelect = 1'b0;
  logic [2:0] stopTimeSel = 3'h0;
  logic cmdReady, busy, txTrigger, modData, sleeping, calibrating, coreReset, edgeMasked;
  logic edgeMasked2;
  int errors = 0;
  int comparisons = 0;
  int coreCnt = 0;
  int calCnt = 0;
  int txCnt = 0;
  int s;
  logic bits[$];
  always #2 clk = ~clk;
  tw_link_if tw_link_if_i ();
  tw_link_if lnkFault ();
  tw_host #(.WaitCycles(30)) tw_host_i (.clk(clk), .sys_rst(sys_rst), .lnk(tw_link_if_i),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReady(cmdReady), .idleLevel(idleLevel),
    .busy(busy));
  tw_device #(.StepCycles(20), .CalCycles(30)) tw_device_i (.clk(clk), .sys_rst(sys_rst),
    .lnk(tw_link_if_i), .startEdgeSelect(startEdgeSelect), .stopTimeSel(stopTimeSel),
    .txTrigger(txTrigger), .modData(modData), .sleeping(sleeping),
    .calibrating(calibrating), .coreReset(coreReset), .edgeMasked(edgeMasked));
  tw_device #(.StepCycles(20), .CalCycles(30)) tw_device_fault_i (.clk(clk),
    .sys_rst(sys_rst), .lnk(lnkFault), .startEdgeSelect(startEdgeSelect),
    .stopTimeSel(stopTimeSel),
    .txTrigger(), .modData(), .sleeping(), .calibrating(), .coreReset(),
    .edgeMasked(edgeMasked2));
  tw_link_props tw_link_props_i (.clk(clk), .sys_rst(sys_rst), .sclk(tw_link_if_i.sclk),
    .dataOut(tw_link_if_i.dataOut), .dataOe(tw_link_if_i.dataOe),
    .dataLine(tw_link_if_i.dataLine));
  always @(negedge tw_link_if_i.sclk) if (!sys_rst) bits.push_back(tw_link_if_i.dataLine);
  always @(negedge clk) begin
    coreCnt += int'(coreReset === 1'b1);
    calCnt += int'(calibrating === 1'b1);
    txCnt += int'(txTrigger === 1'b1);
  end
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic waitReady(input int lim);
    int k;
    k = 0;
    while (cmdReady !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (k >= lim) begin
      errors++;
      $display("CHECK FAILED cmdReady expected 1 seen 0");
    end
  endtask
  task automatic checkBits(input logic [63:0] exp, input int n);
    logic [63:0] got;
    got = '0;
    foreach (bits[i]) got = {got[62:0], bits[i]};
    `CHK("bit count", n, bits.size())
    `CHK("command bits", exp, got)
  endtask
  task automatic doCmd(input logic [2:0] op, input logic [63:0] exp, input int n);
    bits.delete();
    @(negedge clk);
    cmdOp = tw_op_t'(op);
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    `CHK("busy running", 1'b1, busy)
    waitReady(n * 250 + 100);
    `CHK("busy done", 1'b0, busy)
    checkBits(exp, n);
  endtask
  // The bench clocks the fault link at 6 ns, far above the host rate, to stress the crossing.
  task automatic sendBits(input logic [47:0] v);
    lnkFault.dataOe = 1'b1;
    for (int i = 47; i >= 0; i--) begin
      lnkFault.dataOut = v[i];
      #3 lnkFault.sclk = 1'b0;
      #3 lnkFault.sclk = 1'b1;
    end
    lnkFault.dataOe = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  // The device link logic also clears on link clock edges while reset is held, so give it some during reset.
  initial begin
    lnkFault.sclk = 1'b1;
    lnkFault.dataOut = 1'b0;
    lnkFault.dataOe = 1'b0;
    repeat (4) begin
      #3 lnkFault.sclk = 1'b0;
      #3 lnkFault.sclk = 1'b1;
    end
  end
  initial begin
    #380000;
    errors++;
    $display("CHECK FAILED watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    waitReady(20000);
    checkBits({PRE_ZEROS, CMD_PORT_RESET, CMD_CORE_RESET}, 64);
    `CHK("boot mask", 1'b1, edgeMasked)
    `CHK("boot sleep", 1'b1, sleeping)
    `CHK("boot core", 1, coreCnt)
    $display("test boot done");
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        doCmd(3'h0, {16'h0000, PRE_ZEROS, CMD_PORT_RESET}, 48);
        `CHK("masked", 1'b1, edgeMasked)
        txCnt = 0;
        idleLevel = 1'b1;
        repeat (100) @(negedge clk);
        `CHK("masked trigger", 0, txCnt)
        startEdgeSelect = 1'b1;
        stopTimeSel = 3'h7;
      end
      // Selector 7 asks for exactly the longest stop time, nine steps, so the clamp does not act.
      s = (m == 1) ? 9 : 2;
      doCmd(3'h3, {PRE_ZEROS, CMD_PORT_RESET, CMD_PORT_RELEASE}, 64);
      `CHK("unmasked", 1'b0, edgeMasked)
      txCnt = 0;
      idleLevel = ~idleLevel;
      repeat (20) @(negedge clk);
      `CHK("trigger", 1, txCnt)
      `CHK("mod data", idleLevel, modData)
      idleLevel = 1'b0;
      repeat (s * 20 - 25 - 20 * m) @(negedge clk);
      `CHK("early sleep", 1'b0, sleeping)
      repeat (70) @(negedge clk);
      `CHK("stop sleep", 1'b1, sleeping)
      $display("test trigger mode %0d done", m);
    end
    idleLevel = 1'b1;
    coreCnt = 0;
    calCnt = 0;
    doCmd(3'h4, {PRE_ZEROS, CMD_PORT_RESET, CMD_CORE_RESET}, 64);
    repeat (10) @(negedge clk);
    `CHK("core pulses", 1, coreCnt)
    `CHK("calibrated", 1'b1, calCnt > 0)
    `CHK("core sleep", 1'b1, sleeping)
    `CHK("mask kept", 1'b1, edgeMasked)
    $display("test core reset done");
    bits.delete();
    cmdOp = tw_op_t'(3'h5);
    cmdValid = 1'b1;
    repeat (300) @(negedge clk);
    cmdValid = 1'b0;
    `CHK("refused bits", 0, bits.size())
    $display("test refused op done");
    sendBits({PRE_ZEROS, CMD_PORT_RESET});
    `CHK("fault mask", 1'b1, edgeMasked2)
    sendBits(48'h1234_0000_0000);
    `CHK("unknown word", 1'b1, edgeMasked2)
    sendBits({32'h0000_0000, CMD_PORT_RELEASE});
    `CHK("fault release", 1'b0, edgeMasked2)
    sendBits(48'h0000_0001_8D00);
    `CHK("dirty zeros", 1'b0, edgeMasked2)
    $display("test fault link done");
    finish_test();
  end
endmodule
`default_nettype wire

// [tb/tw_link_props.sv]
// Link-level assertions between the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
module tw_link_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic dataLine
);
  logic sclkPrev_q;
  logic [8:0] runCnt_q;
  // The run counter saturates so that a long idle phase never wraps into a short one.
  always_ff @(posedge clk) begin
    sclkPrev_q <= sys_rst ? 1'b1 : sclk;
    if (sys_rst) begin
      runCnt_q <= 9'h1FF;
    end else if (sclk != sclkPrev_q) begin
      runCnt_q <= 9'h001;
    end else if (runCnt_q != 9'h1FF) begin
      runCnt_q <= runCnt_q + 9'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_idle_after_reset: assert property ($fell(sys_rst) |-> sclk && !dataOut)
    else $error("link not idle after reset");
  a_line_driven: assert property (dataOe)
    else $error("host released the data line");
  a_data_on_rise: assert property ($changed(dataOut) |-> sclk)
    else $error("data changed while clock low");
  a_data_setup: assert property ($fell(sclk) |-> dataOut == $past(dataOut, 5))
    else $error("data setup too short");
  a_data_hold: assert property ($fell(sclk) |-> $stable(dataOut)[*8])
    else $error("data hold too short");
  a_low_phase: assert property ($fell(sclk) |-> ##124 !sclk ##1 sclk)
    else $error("clock low phase not 125 cycles");
  a_phase_min: assert property ((sclk != sclkPrev_q) |-> runCnt_q >= 9'h07D)
    else $error("clock phase shorter than 125 cycles");
  a_first_fall_gap: assert property ($fell(dataLine) |-> sclk[*5])
    else $error("clock fell too soon after data fell");
endmodule
`default_nettype wire
